// ===== dfe_frontend.sv
// Purpose: Pin front end of a dual-rank DDR3 device: per-rank command gating,
//          write masking, termination control and data/strobe direction.
// Assumes: clk stands for the CK/CK# crossing; one data beat per edge.
// Notes: Unmasked write beats queue in a 16-word FIFO toward the core side.
`timescale 1ns/1ps

module dfe_frontend #(
  parameter bit X8 = 1'b1,
  parameter int DEPTH = dfe_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic dev_reset_n,
  input wire logic [dfe_pkg::RANKS-1:0] cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [dfe_pkg::BA_W-1:0] ba,
  input wire logic [dfe_pkg::ADDR_W-1:0] addr,
  input wire logic [dfe_pkg::RANKS-1:0] odt,
  input wire logic dm,
  input wire logic [dfe_pkg::DQ_MAX-1:0] dq_in,
  output logic [dfe_pkg::DQ_MAX-1:0] dq_out,
  output logic [dfe_pkg::DQ_MAX-1:0] dq_oe,
  input wire logic dqs_in,
  output logic dqs_out,
  output logic dqs_n_out,
  output logic dqs_oe,
  output logic [dfe_pkg::RANKS-1:0] cmd_valid,
  output logic [dfe_pkg::RANKS*dfe_pkg::CMD_W-1:0] cmd_code,
  output logic [dfe_pkg::RANKS-1:0] odt_on,
  output logic [dfe_pkg::DQ_MAX-1:0] term_dq,
  output logic term_dqs,
  output logic term_dm,
  output logic term_tdqs,
  output logic rd_req,
  input wire logic [dfe_pkg::DQ_MAX-1:0] rd_data,
  output logic wr_valid,
  output logic wr_rank,
  output logic [dfe_pkg::DQ_MAX-1:0] wr_data,
  input wire logic wr_ready,
  output logic overrun
);
  localparam int WORD_W = dfe_pkg::DQ_MAX + 1;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    dfe_pkg::dfe_mode_t mode;
    logic [dfe_pkg::BEAT_W-1:0] beat;
    logic rank;
    logic dqs_prev;
    logic [dfe_pkg::RANKS-1:0] term_en;
    logic [dfe_pkg::RANKS-1:0] tdqs_en;
    logic [dfe_pkg::RANKS-1:0] cmd_valid;
    logic [dfe_pkg::RANKS*dfe_pkg::CMD_W-1:0] cmd_code;
    logic [dfe_pkg::RANKS-1:0] odt_on;
    logic [dfe_pkg::DQ_MAX-1:0] term_dq;
    logic term_dqs;
    logic term_dm;
    logic term_tdqs;
    logic [dfe_pkg::DQ_MAX-1:0] dq_out;
    logic [dfe_pkg::DQ_MAX-1:0] dq_oe;
    logic dqs_out;
    logic dqs_n_out;
    logic dqs_oe;
    logic rd_req;
    logic overrun;
  } dfe_state_t;

  dfe_state_t st;
  dfe_state_t next_st;
  logic [dfe_pkg::DQ_MAX-1:0] lane_live;
  logic write_beat;
  logic beat_kept;
  logic dm_active;
  logic any_odt;
  logic tdqs_active;
  logic [dfe_pkg::CMD_W-1:0] rank_code [dfe_pkg::RANKS];

  dfe_stream_if #(.WIDTH(WORD_W)) fill_if ();
  dfe_stream_if #(.WIDTH(WORD_W)) drain_if ();

  // ****************************************************************
  // Lane map
  // ****************************************************************
  // Upper lanes exist only on x8; on x4 those balls never drive or terminate.
  for (genvar i = 0; i < dfe_pkg::DQ_MAX; i++) begin : g_lane
    assign lane_live[i] = X8 || (i < dfe_pkg::DQ_X4);
  end

  // Each rank builds its own code from its own chip select.
  for (genvar r = 0; r < dfe_pkg::RANKS; r++) begin : g_rank
    assign rank_code[r] = {cs_n[r], ras_n, cas_n, we_n};
  end

  // ****************************************************************
  // Write beat capture
  // ****************************************************************
  // A beat is one strobe transition; the strobe is centred in the eye, so the
  // data sampled on the same edge is stable.
  assign write_beat = (st.mode == dfe_pkg::DFE_WRITING) && (dqs_in != st.dqs_prev);
  assign dm_active = ~(X8 && st.tdqs_en[st.rank]);
  assign beat_kept = write_beat && !(dm_active && dm);
  assign fill_if.valid = beat_kept;
  assign fill_if.data = {st.rank, dq_in & lane_live};

  always_comb begin
    next_st = st;
    any_odt = 1'b0;
    tdqs_active = 1'b0;
    next_st.dqs_prev = dqs_in;
    next_st.cmd_valid = '0;
    // Command decode, one rank at a time, each on its own chip select.
    for (int r = 0; r < dfe_pkg::RANKS; r++) begin
      next_st.cmd_code[r*dfe_pkg::CMD_W +: dfe_pkg::CMD_W] = rank_code[r];
      if (!cs_n[r]) begin
        next_st.cmd_valid[r] = 1'b1;
        if (rank_code[r] == dfe_pkg::CMD_LOAD_MODE && ba == dfe_pkg::MR_TERM_SEL) begin
          next_st.term_en[r] = |(addr & dfe_pkg::MR_TERM_MASK);
          next_st.tdqs_en[r] = addr[dfe_pkg::MR_TDQS_BIT] & X8;
        end
      end
      // Termination input counts only while its rank has termination on.
      next_st.odt_on[r] = odt[r] & st.term_en[r];
      any_odt = any_odt | st.odt_on[r];
      tdqs_active = tdqs_active | (st.odt_on[r] & st.tdqs_en[r]);
    end
    // Termination drops one cycle after this device starts driving the bus and returns one cycle after it stops.
    any_odt = any_odt & ~st.dqs_oe;
    next_st.term_dq = any_odt ? lane_live : '0;
    next_st.term_dqs = any_odt;
    next_st.term_dm = any_odt & ~tdqs_active;
    next_st.term_tdqs = any_odt & tdqs_active;
    if (fill_if.valid && !fill_if.ready) begin
      next_st.overrun = 1'b1;
    end
    next_st.dq_oe = '0;
    next_st.dqs_oe = 1'b0;
    next_st.rd_req = 1'b0;
    unique case (st.mode)
      dfe_pkg::DFE_IDLE: begin
        next_st.beat = '0;
        next_st.dqs_out = 1'b0;
        next_st.dqs_n_out = 1'b1;
        for (int r = dfe_pkg::RANKS - 1; r >= 0; r--) begin
          if (!cs_n[r] && rank_code[r] == dfe_pkg::CMD_WRITE) begin
            next_st.mode = dfe_pkg::DFE_WRITING;
            next_st.rank = r[0];
          end else if (!cs_n[r] && rank_code[r] == dfe_pkg::CMD_READ) begin
            next_st.mode = dfe_pkg::DFE_READING;
            next_st.rank = r[0];
            next_st.rd_req = 1'b1;
          end
        end
      end
      dfe_pkg::DFE_WRITING: begin
        // The bus stays an input for the whole write burst.
        if (write_beat) begin
          next_st.beat = dfe_pkg::BEAT_W'(st.beat + 1'b1);
          if (st.beat == dfe_pkg::BEAT_LAST) begin
            next_st.mode = dfe_pkg::DFE_IDLE;
          end
        end
      end
      dfe_pkg::DFE_READING: begin
        // Data and strobe leave on the same edge, so their transitions align.
        next_st.dq_out = rd_data & lane_live;
        next_st.dq_oe = lane_live;
        next_st.dqs_out = ~st.dqs_out;
        next_st.dqs_n_out = st.dqs_out;
        next_st.dqs_oe = 1'b1;
        next_st.beat = dfe_pkg::BEAT_W'(st.beat + 1'b1);
        next_st.rd_req = (st.beat != dfe_pkg::BEAT_LAST);
        if (st.beat == dfe_pkg::BEAT_LAST) begin
          next_st.mode = dfe_pkg::DFE_IDLE;
        end
      end
      default: begin
        next_st.mode = dfe_pkg::DFE_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // The device reset pin clears state at once; reset_n is the system's own.
  always_ff @(posedge clk or negedge dev_reset_n) begin
    if (!dev_reset_n) begin
      st <= '0;
      st.mode <= dfe_pkg::DFE_IDLE;
      st.term_en <= dfe_pkg::TERM_EN_RESET;
      st.tdqs_en <= dfe_pkg::TDQS_EN_RESET;
      st.dqs_n_out <= 1'b1;
    end else if (!reset_n) begin
      st <= '0;
      st.mode <= dfe_pkg::DFE_IDLE;
      st.term_en <= dfe_pkg::TERM_EN_RESET;
      st.tdqs_en <= dfe_pkg::TDQS_EN_RESET;
      st.dqs_n_out <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  dfe_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .dev_reset_n(dev_reset_n),
    .fill(fill_if),
    .drain(drain_if)
  );

  assign drain_if.ready = wr_ready;
  assign wr_valid = drain_if.valid;
  assign wr_rank = drain_if.data[WORD_W-1];
  assign wr_data = drain_if.data[dfe_pkg::DQ_MAX-1:0];

  assign dq_out = st.dq_out;
  assign dq_oe = st.dq_oe;
  assign dqs_out = st.dqs_out;
  assign dqs_n_out = st.dqs_n_out;
  assign dqs_oe = st.dqs_oe;
  assign cmd_valid = st.cmd_valid;
  assign cmd_code = st.cmd_code;
  assign odt_on = st.odt_on;
  assign term_dq = st.term_dq;
  assign term_dqs = st.term_dqs;
  assign term_dm = st.term_dm;
  assign term_tdqs = st.term_tdqs;
  assign rd_req = st.rd_req;
  assign overrun = st.overrun;
endmodule

// ===== dfe_pkg.sv
// Purpose: Shared constants and types of the dual-rank DDR3 pin front end.
// Assumes: One command slot and one data beat per clk edge.
// Notes: Command codes are the packed {cs_n, ras_n, cas_n, we_n} of one edge.
package dfe_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int RANKS = 2;
  localparam int DQ_MAX = 8;
  localparam int DQ_X4 = 4;
  localparam int BA_W = 3;
  localparam int ADDR_W = 15;
  localparam int CMD_W = 4;
  localparam int BURST_BEATS = 8;
  localparam int BEAT_W = 3;
  localparam int FIFO_DEPTH = 16;

  // ****************************************************************
  // Command codes and mode register fields
  // ****************************************************************
  localparam logic [CMD_W-1:0] CMD_LOAD_MODE = 4'h0;
  localparam logic [CMD_W-1:0] CMD_WRITE = 4'h4;
  localparam logic [CMD_W-1:0] CMD_READ = 4'h5;
  localparam logic [BA_W-1:0] MR_TERM_SEL = 3'h1;
  localparam logic [ADDR_W-1:0] MR_TERM_MASK = 15'h0244;
  localparam int MR_TDQS_BIT = 11;
  localparam logic [RANKS-1:0] TERM_EN_RESET = 2'h3;
  localparam logic [RANKS-1:0] TDQS_EN_RESET = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_LAST = 3'h7;

  typedef enum logic [1:0] {
    DFE_IDLE,
    DFE_WRITING,
    DFE_READING
  } dfe_mode_t;

endpackage

// ===== dfe_stream_if.sv
// Purpose: Valid/ready word carrier between the front end and its buffer.
// Assumes: Both sides on clk.
// Notes: A word moves on an edge where valid and ready are both high.
`timescale 1ns/1ps
interface dfe_stream_if #(
  parameter int WIDTH = 9
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== dfe_fifo.sv
// Purpose: Flip-flop FIFO holding accepted write beats.
// Assumes: Synchronous reset plus the asynchronous device reset.
// Notes: Full and empty are registered flags, so ready and valid are flops.
`timescale 1ns/1ps
module dfe_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic dev_reset_n,
  dfe_stream_if.snk fill,
  dfe_stream_if.src drain
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic full;
    logic empty;
  } dfe_fifo_state_t;

  dfe_fifo_state_t st;
  dfe_fifo_state_t next_st;
  logic push;
  logic pop;
  logic [PW:0] next_count;

  assign fill.ready = ~st.full;
  assign drain.valid = ~st.empty;
  assign drain.data = st.mem[st.rd_ptr];
  assign push = fill.valid & ~st.full;
  assign pop = drain.ready & ~st.empty;

  always_comb begin
    next_st = st;
    next_count = st.count;
    if (push) begin
      next_st.mem[st.wr_ptr] = fill.data;
      next_st.wr_ptr = PW'(st.wr_ptr + 1'b1);
    end
    if (pop) begin
      next_st.rd_ptr = PW'(st.rd_ptr + 1'b1);
    end
    if (push && !pop) begin
      next_count = (PW+1)'(st.count + 1'b1);
    end else if (pop && !push) begin
      next_count = (PW+1)'(st.count - 1'b1);
    end
    next_st.count = next_count;
    next_st.full = (next_count == (PW+1)'(DEPTH));
    next_st.empty = (next_count == '0);
  end

  always_ff @(posedge clk or negedge dev_reset_n) begin
    if (!dev_reset_n) begin
      st <= '{mem: '0, wr_ptr: '0, rd_ptr: '0, count: '0, full: 1'b0, empty: 1'b1};
    end else if (!reset_n) begin
      st <= '{mem: '0, wr_ptr: '0, rd_ptr: '0, count: '0, full: 1'b0, empty: 1'b1};
    end else begin
      st <= next_st;
    end
  end
endmodule

// ===== dfe_monitor.sv
// Purpose: Port assertions for the DDR3 pin front end.
// Assumes: One clk domain; either reset disarms the checks, except a_dev_clear, which only reset_n disarms.
// Notes: Bound into every front end instance.
`timescale 1ns/1ps
module dfe_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic dev_reset_n,
  input wire logic [1:0] cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] odt,
  input wire logic dqs_out,
  input wire logic dqs_n_out,
  input wire logic dqs_oe,
  input wire logic [1:0] cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [1:0] odt_on,
  input wire logic [7:0] term_dq,
  input wire logic term_dqs,
  input wire logic rd_req
);
  // The guard flop keeps the first edge after either reset out of a_cmd_gate, a_cmd_code and a_odt_src.
  logic armed;
  logic [1:0] cs_q;
  logic [2:0] op_q;
  always_ff @(posedge clk) begin
    armed <= reset_n && dev_reset_n;
    cs_q <= cs_n;
    op_q <= {ras_n, cas_n, we_n};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n || !dev_reset_n);
  a_cmd_gate: assert property (armed |-> cmd_valid == ~cs_q)
    else $error("command valid does not follow chip select");
  a_cmd_code: assert property (armed |-> cmd_code == {cs_q[1], op_q, cs_q[0], op_q})
    else $error("command code wrong");
  a_odt_src: assert property (armed |-> (odt_on & ~$past(odt)) == 2'h0)
    else $error("termination on without its input");
  a_read_len: assert property ($rose(rd_req) |-> rd_req [*8] ##1 !rd_req)
    else $error("read burst length wrong");
  a_strobe_pair: assert property (dqs_oe |-> dqs_n_out == !dqs_out)
    else $error("strobe pair not complementary");
  a_strobe_toggle: assert property (dqs_oe && $past(dqs_oe) |-> dqs_out != $past(dqs_out))
    else $error("read strobe did not toggle");
  a_term_quiet: assert property (dqs_oe && $past(dqs_oe) |-> term_dq == 8'h00 && !term_dqs)
    else $error("termination while driving");
  a_dev_clear: assert property (disable iff (!reset_n)
    !dev_reset_n |-> odt_on == 2'h0 && cmd_valid == 2'h0 && !dqs_oe && dqs_n_out)
    else $error("device reset did not clear outputs");
endmodule
bind dfe_frontend dfe_monitor u_dfe_monitor (.clk(clk), .reset_n(reset_n),
  .dev_reset_n(dev_reset_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
  .odt(odt), .dqs_out(dqs_out), .dqs_n_out(dqs_n_out), .dqs_oe(dqs_oe),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .odt_on(odt_on), .term_dq(term_dq),
  .term_dqs(term_dqs), .rd_req(rd_req));

// ===== dfe_ctrl_model.sv
// Purpose: Memory controller model driving command, termination and write data.
// Assumes: One beat per clk; signals change just after a rising edge.
// Notes: Deselected command lines wander so that gating faults show.
`timescale 1ns/1ps
module dfe_ctrl_model (
  input wire logic clk,
  output logic [1:0] cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [14:0] addr,
  output logic [1:0] odt,
  output logic dm,
  output logic [7:0] dq_in,
  output logic dqs_in
);
  initial begin
    cs_n = 2'h3;
    {ras_n, cas_n, we_n} = 3'h7;
    {ba, addr, odt, dm, dq_in, dqs_in} = '0;
  end
  task automatic cmd(input int r, input logic [2:0] op, input logic [2:0] b, input logic [14:0] a);
    @(posedge clk);
    cs_n <= ~(2'h1 << r);
    {ras_n, cas_n, we_n} <= op;
    ba <= b;
    addr <= a;
  endtask
  task automatic idle();
    @(posedge clk);
    cs_n <= 2'h3;
    {ras_n, cas_n, we_n} <= ~{ras_n, cas_n, we_n};
    addr <= ~addr;
    dq_in <= ~dq_in;
  endtask
  task automatic beat(input logic [7:0] d, input logic m);
    @(posedge clk);
    cs_n <= 2'h3;
    dqs_in <= ~dqs_in;
    dq_in <= d;
    dm <= m;
  endtask
  task automatic set_odt(input logic [1:0] v);
    @(posedge clk);
    odt <= v;
  endtask
endmodule

// ===== tb.sv
// Purpose: Self-checking bench for the DDR3 pin front end.
// Assumes: X8 build with a 16 word buffer.
// Notes: The core side stalls while bursts overfill the buffer.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic dev_reset_n = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic wr_ready = 1'b0;
  logic [1:0] cs_n, odt, cmd_valid, odt_on;
  logic ras_n, cas_n, we_n, dm, dqs_in, dqs_out, dqs_n_out, dqs_oe;
  logic term_dqs, term_dm, term_tdqs, rd_req, wr_valid, wr_rank, overrun;
  logic [2:0] ba;
  logic [14:0] addr;
  logic [7:0] dq_in, dq_out, dq_oe, cmd_code, term_dq, wr_data;
  logic [8:0] exp[$];
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  dfe_ctrl_model u_dfe_ctrl_model (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .dm(dm), .dq_in(dq_in), .dqs_in(dqs_in));
  dfe_frontend #(.X8(1'b1), .DEPTH(16)) u_dfe_frontend (.clk(clk), .reset_n(reset_n),
    .dev_reset_n(dev_reset_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .odt(odt), .dm(dm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_n_out(dqs_n_out), .dqs_oe(dqs_oe),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .odt_on(odt_on), .term_dq(term_dq),
    .term_dqs(term_dqs), .term_dm(term_dm), .term_tdqs(term_tdqs), .rd_req(rd_req),
    .rd_data(rd_data), .wr_valid(wr_valid), .wr_rank(wr_rank), .wr_data(wr_data),
    .wr_ready(wr_ready), .overrun(overrun));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic idle(input int n);
    repeat (n) u_dfe_ctrl_model.idle();
    #1;
  endtask
  task automatic mrs(input logic [14:0] a);
    u_dfe_ctrl_model.cmd(0, dfe_pkg::CMD_LOAD_MODE[2:0], dfe_pkg::MR_TERM_SEL, a);
  endtask
  task automatic wr_burst(input int r, input logic [7:0] base, input logic [7:0] mask, input bit keep);
    u_dfe_ctrl_model.cmd(r, dfe_pkg::CMD_WRITE[2:0], 3'h0, 15'h0000);
    for (int k = 0; k < 8; k++) begin
      u_dfe_ctrl_model.beat(base + 8'(k), mask[k]);
      if (!mask[k] || keep) exp.push_back({r[0], base + 8'(k)});
    end
    idle(2);
  endtask
  task automatic drain(input int n);
    logic [8:0] w;
    @(posedge clk) wr_ready <= 1'b1;
    repeat (n) begin
      #1;
      w = exp.pop_front();
      chk("wr_word", {wr_valid, wr_rank, wr_data}, {1'b1, w});
      @(posedge clk);
    end
    wr_ready <= 1'b0;
    #1;
    chk("wr_empty", wr_valid, 1'b0);
  endtask
  task automatic t_term();
    u_dfe_ctrl_model.set_odt(2'h3);
    idle(2);
    chk("term_on", {odt_on, term_dq, term_dqs, term_dm, term_tdqs}, 13'h1FFE);
    mrs(15'h0000);
    idle(1);
    chk("cmd", {cmd_valid, cmd_code}, 10'h180);
    idle(2);
    chk("odt_off", odt_on, 2'h2);
    mrs(15'h0040);
    idle(3);
    chk("odt_back", odt_on, 2'h3);
  endtask
  task automatic t_fill();
    wr_burst(1, 8'h10, 8'h24, 1'b0);
    wr_burst(0, 8'h20, 8'h00, 1'b0);
    wr_burst(0, 8'h30, 8'h00, 1'b0);
    chk("overrun", overrun, 1'b1);
    while (exp.size() > 16) exp.pop_back();
    drain(16);
  endtask
  task automatic t_tdqs();
    mrs(15'h0804);
    idle(4);
    chk("tdqs_term", {term_dm, term_tdqs}, 2'h1);
    wr_burst(0, 8'h40, 8'hFF, 1'b1);
    drain(8);
  endtask
  task automatic t_read();
    u_dfe_ctrl_model.cmd(1, dfe_pkg::CMD_READ[2:0], 3'h0, 15'h0000);
    for (int i = 0; i < 10; i++) begin
      u_dfe_ctrl_model.idle();
      rd_data <= 8'hA0 + 8'(i);
      #1;
      chk("rd_req", rd_req, i < 8);
      if (i >= 1 && i <= 8) begin
        chk("dq_out", {dq_out, dq_oe}, {8'hA0 + 8'(i - 1), 8'hFF});
        chk("dqs", {dqs_out, dqs_n_out}, {i[0], !i[0]});
      end
      if (i == 5) chk("term_quiet", {term_dq, term_dqs}, 9'h000);
      if (i == 9) chk("dqs_oe", {dq_oe, dqs_oe}, 9'h000);
    end
  endtask
  task automatic t_dev_reset();
    @(posedge clk) dev_reset_n <= 1'b0;
    #2;
    chk("async_clear", {odt_on, dqs_n_out, overrun}, 4'h2);
    @(posedge clk) dev_reset_n <= 1'b1;
    idle(2);
    chk("after_reset", {odt_on, term_dm, term_tdqs}, 4'hE);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    dev_reset_n <= 1'b1;
    idle(1);
    chk("reset_out", {cmd_valid, odt_on, dqs_n_out, wr_valid, overrun}, 7'h04);
    t_term();
    t_fill();
    t_tdqs();
    t_read();
    t_dev_reset();
    close_out();
  end
endmodule
